/* File: hdl/modbus_output_write_analog_read.sv */
// request handler: single/multiple output write and analog input read
`timescale 1ns/100ps
module modbus_output_write_analog_read
  import modbus_slave_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] unit_addr,
  input rx_byte_t rx,
  input wire logic tx_ready,
  output tx_byte_t tx,
  output logic [NUM_OUT-1:0] coil_state,
  input wire logic [NUM_AI-1:0][31:0] analog_input_channel
);

  // ****************************************************************
  // state
  // ****************************************************************
  state_t state_q, state_d;
  logic [7:0] rx_buf_q [BUF_LEN];
  logic [4:0] rx_cnt_q;
  logic [15:0] rx_crc_q;
  logic [15:0] tx_crc_q, tx_crc_d;
  logic [5:0] tx_idx_q, tx_idx_d;
  tx_byte_t tx_q, tx_d;
  logic [NUM_OUT-1:0] coil_q, coil_d;
  logic [31:0] ai_q [NUM_AI];

  // ****************************************************************
  // request decode
  // ****************************************************************
  wire in_idle = (state_q == ST_IDLE);
  wire in_exec = (state_q == ST_EXEC);
  wire [7:0] fc = rx_buf_q[POS_FC];
  wire [15:0] start16 = {rx_buf_q[POS_REG_HI], rx_buf_q[POS_REG_LO]};
  wire [15:0] val16 = {rx_buf_q[POS_VAL_HI], rx_buf_q[POS_VAL_LO]};
  wire [7:0] byte_cnt = rx_buf_q[POS_BC];
  wire [15:0] wdata = {rx_buf_q[POS_DATA1], rx_buf_q[POS_DATA0]};
  wire [16:0] end17 = 17'(start16) + 17'(val16);
  wire count_ok = (val16 != 16'h0000) && (val16 <= 16'(NUM_OUT));
  wire [4:0] bytes_need = 5'((val16[4:0] + BYTE_ROUND) >> BYTE_SHIFT);
  wire unit_ok = (unit_addr >= UNIT_MIN) && (unit_addr <= UNIT_MAX);
  wire addr_ok = unit_ok && (rx_buf_q[POS_ADDR] == unit_addr);
  wire crc_ok = (rx_crc_q == 16'h0000);

  // single write: exact length, output in range, legal action
  wire is_single = (fc == FC_WR_SINGLE) && (rx_cnt_q == LEN_FIXED)
    && (start16 < 16'(NUM_OUT))
    && ((val16 == VAL_CLOSE) || (val16 == VAL_OPEN));

  // multi write: byte count must match output count and frame length
  wire is_multi = (fc == FC_WR_MULTI) && count_ok
    && (end17 <= 17'(NUM_OUT))
    && (byte_cnt == {3'b000, bytes_need})
    && (rx_cnt_q == LEN_MULTI_HDR + byte_cnt[4:0]);

  wire is_read = (fc == FC_RD_INPUT) && (rx_cnt_q == LEN_FIXED)
    && (val16 != 16'h0000)
    && (end17 <= 17'(NUM_IREG));

  // anything else is dropped without an exception reply
  wire accept = in_idle && rx.eof && crc_ok && addr_ok
    && (is_single || is_multi || is_read);

  // ****************************************************************
  // receive side
  // ****************************************************************
  wire tx_fire = tx_q.valid && tx_ready;
  wire rx_take = in_idle && rx.valid;
  wire rx_restart = (in_idle && rx.eof && !accept)
    || ((state_q == ST_CRC_HI) && tx_fire);

  // bytes beyond the buffer still run the checksum and the count,
  // so an oversize frame fails the length test instead of aliasing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_cnt_q <= 5'h00;
      rx_crc_q <= CRC_INIT;
      for (int i = 0; i < BUF_LEN; i++) begin
        rx_buf_q[i] <= 8'h00;
      end
    end else if (rx_take) begin
      if (rx_cnt_q < RX_FULL) begin
        rx_buf_q[rx_cnt_q[3:0]] <= rx.data;
      end
      if (rx_cnt_q != RX_SAT) begin
        rx_cnt_q <= rx_cnt_q + 5'h01;
      end
      rx_crc_q <= crc16_step(rx_crc_q, rx.data);
    end else if (rx_restart) begin
      rx_cnt_q <= 5'h00;
      rx_crc_q <= CRC_INIT;
    end
  end

  // ****************************************************************
  // outputs, one bit per channel
  // ****************************************************************
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    localparam logic [4:0] IDX = 5'(i);
    wire [4:0] off = IDX - start16[4:0];
    wire hit_one = is_single && (start16[4:0] == IDX);
    wire hit_many = is_multi && (IDX >= start16[4:0])
      && (17'(IDX) < end17);
    assign coil_d[i] = !in_exec ? coil_q[i]
      : hit_one ? (val16 == VAL_CLOSE)
      : hit_many ? wdata[off[3:0]]
      : coil_q[i];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coil_q <= '0;
    end else begin
      coil_q <= coil_d;
    end
  end

  assign coil_state = coil_q;

  // analog values frozen at execution so a reply never mixes samples
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int c = 0; c < NUM_AI; c++) begin
        ai_q[c] <= 32'h0000_0000;
      end
    end else if (in_exec) begin
      for (int c = 0; c < NUM_AI; c++) begin
        ai_q[c] <= analog_input_channel[c];
      end
    end
  end

  // ****************************************************************
  // reply byte selection
  // ****************************************************************
  wire [5:0] resp_len = is_read
    ? LEN_RD_HDR + {val16[4:0], 1'b0}
    : LEN_ECHO;
  wire [5:0] nidx = tx_idx_q + 6'h01;
  wire body_done = (nidx == resp_len);
  wire [5:0] dk = nidx - LEN_RD_HDR;
  wire [4:0] reg_idx = start16[4:0] + dk[5:1];
  wire [2:0] ch = reg_idx[3:1];
  wire [1:0] sel = {reg_idx[0], dk[0]};
  wire [31:0] ai_word = ai_q[ch];
  wire [7:0] ai_byte = 8'(ai_word >> {~sel, 3'b000});
  wire [7:0] rd_count = {val16[6:0], 1'b0};
  wire [7:0] next_byte = (is_read && (nidx == POS_COUNT)) ? rd_count
    : (is_read && (nidx >= LEN_RD_HDR)) ? ai_byte
    : rx_buf_q[nidx[3:0]];
  wire [15:0] crc_next = crc16_step(tx_crc_q, tx_q.data);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    tx_d = tx_q;
    tx_idx_d = tx_idx_q;
    tx_crc_d = tx_crc_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_d = ST_BODY;
        tx_d = '{valid: 1'b1, last: 1'b0, data: rx_buf_q[POS_ADDR]};
        tx_idx_d = 6'h00;
        tx_crc_d = CRC_INIT;
      end
      ST_BODY: begin
        if (tx_fire) begin
          tx_crc_d = crc_next;
          tx_idx_d = nidx;
          if (body_done) begin
            state_d = ST_CRC_LO;
            tx_d.data = crc_next[7:0];
          end else begin
            tx_d.data = next_byte;
          end
        end
      end
      ST_CRC_LO: begin
        if (tx_fire) begin
          state_d = ST_CRC_HI;
          tx_d.data = tx_crc_q[15:8];
          tx_d.last = 1'b1;
        end
      end
      ST_CRC_HI: begin
        if (tx_fire) begin
          state_d = ST_IDLE;
          tx_d = '{valid: 1'b0, last: 1'b0, data: 8'h00};
        end
      end
      default: begin
        state_d = ST_IDLE;
        tx_d = '{valid: 1'b0, last: 1'b0, data: 8'h00};
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      tx_q <= '{valid: 1'b0, last: 1'b0, data: 8'h00};
      tx_idx_q <= 6'h00;
      tx_crc_q <= CRC_INIT;
    end else begin
      state_q <= state_d;
      tx_q <= tx_d;
      tx_idx_q <= tx_idx_d;
      tx_crc_q <= tx_crc_d;
    end
  end

  assign tx = tx_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_OWN_ADDR:
  assert property (@(posedge clk) disable iff (sys_rst)
    in_exec |-> (rx_buf_q[POS_ADDR] == unit_addr) && unit_ok)
  else $error("frame executed for a foreign unit address");

  AST_DISCARD:
  assert property (@(posedge clk) disable iff (sys_rst)
    (in_idle && rx.eof && (!crc_ok || !addr_ok)) |=> in_idle ##1 in_idle)
  else $error("rejected frame produced activity");

  AST_CRC_HI_FOLLOWS:
  assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_CRC_LO && tx_fire)
      |=> tx_q.last && (tx_q.data == $past(tx_crc_q[15:8])))
  else $error("crc high byte not sent after low byte");

  AST_SINGLE_CLOSE:
  assert property (@(posedge clk) disable iff (sys_rst)
    (in_exec && is_single && val16 == VAL_CLOSE)
      |=> coil_q[$past(start16[3:0])])
  else $error("single write did not close the output");

  AST_SINGLE_OPEN:
  assert property (@(posedge clk) disable iff (sys_rst)
    (in_exec && is_single && val16 == VAL_OPEN)
      |=> !coil_q[$past(start16[3:0])] ##1 tx_q.valid)
  else $error("single write did not open the output");

  AST_ECHO:
  assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_BODY && is_single)
      |-> tx_q.data == rx_buf_q[tx_idx_q[3:0]])
  else $error("single write reply differs from request");

  AST_MULTI_FIRST_BIT:
  assert property (@(posedge clk) disable iff (sys_rst)
    (in_exec && is_multi)
      |=> coil_q[$past(start16[3:0])] == $past(rx_buf_q[POS_DATA0][0]))
  else $error("first data bit not applied to start output");

  AST_MULTI_LEN:
  assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_CRC_LO && is_multi) |-> tx_idx_q == LEN_ECHO)
  else $error("multi write reply length wrong");

  AST_READ_COUNT:
  assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_BODY && is_read && tx_idx_q == POS_COUNT)
      |-> tx_q.data == {val16[6:0], 1'b0})
  else $error("read reply byte count is not twice the count");

  AST_TX_HOLD:
  assert property (@(posedge clk) disable iff (sys_rst)
    (tx_q.valid && !tx_ready) |=> $stable(tx_q.data) && tx_q.valid)
  else $error("reply byte changed while stalled");

  AST_READ_MSB_FIRST:
  assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_BODY && is_read && !start16[0]
      && tx_idx_q == LEN_RD_HDR)
      |-> tx_q.data == ai_q[start16[3:1]][31:24])
  else $error("analog value not sent most significant byte first");

  AST_COIL_HOLD:
  assert property (@(posedge clk) disable iff (sys_rst)
    !in_exec |=> $stable(coil_q))
  else $error("outputs changed outside an accepted request");

endmodule // modbus_output_write_analog_read

/* File: include/modbus_slave_pkg.sv */
// constants, carriers and checksum step for the output/analog request handler
package modbus_slave_pkg;

  // ****************************************************************
  // sizes and frame layout
  // ****************************************************************
  localparam int BUF_LEN = 16;
  localparam int NUM_OUT = 16;
  localparam int NUM_AI = 8;
  localparam int NUM_IREG = 2 * NUM_AI;
  localparam logic [4:0] RX_FULL = 5'h10;
  localparam logic [4:0] RX_SAT = 5'h1F;
  localparam logic [4:0] LEN_FIXED = 5'h08;
  localparam logic [4:0] LEN_MULTI_HDR = 5'h09;
  localparam logic [5:0] LEN_ECHO = 6'h06;
  localparam logic [5:0] LEN_RD_HDR = 6'h03;
  localparam logic [5:0] POS_COUNT = 6'h02;
  localparam int POS_ADDR = 0;
  localparam int POS_FC = 1;
  localparam int POS_REG_HI = 2;
  localparam int POS_REG_LO = 3;
  localparam int POS_VAL_HI = 4;
  localparam int POS_VAL_LO = 5;
  localparam int POS_BC = 6;
  localparam int POS_DATA0 = 7;
  localparam int POS_DATA1 = 8;

  // ****************************************************************
  // codes and values
  // ****************************************************************
  localparam logic [7:0] FC_WR_SINGLE = 8'h05;
  localparam logic [7:0] FC_WR_MULTI = 8'h0F;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [15:0] VAL_CLOSE = 16'hFF00;
  localparam logic [15:0] VAL_OPEN = 16'h0000;
  localparam logic [7:0] UNIT_MIN = 8'h01;
  localparam logic [7:0] UNIT_MAX = 8'hF7;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [4:0] BYTE_ROUND = 5'h07;
  localparam int BYTE_SHIFT = 3;

  // ****************************************************************
  // carriers and states
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic eof;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } tx_byte_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_EXEC = 5'h02,
    ST_BODY = 5'h04,
    ST_CRC_LO = 5'h08,
    ST_CRC_HI = 5'h10
  } state_t;

  // reflected crc-16, one byte per call
  function automatic logic [15:0] crc16_step(input logic [15:0] crc,
                                             input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int b = 0; b < 8; b++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

/* File: sim/modbus_master_sink.sv */
// master-side model that takes the handler's reply bytes
`timescale 1ns/100ps
module modbus_master_sink
  import modbus_slave_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  input tx_byte_t tx,
  output logic tx_ready
);
  // ********
  // reply capture
  // ********
  logic [8:0] got[$];
  initial tx_ready = 1'b0;
  // a slow master takes a byte only every other cycle
  always @(negedge clk) begin
    tx_ready <= stall ? ~tx_ready : 1'b1;
  end
  always @(posedge clk) begin
    if (tx.valid && tx_ready) got.push_back({tx.last, tx.data});
  end
endmodule // modbus_master_sink

/* File: sim/modbus_output_write_analog_read_test.sv */
// self-checking bench for the output write and analog read handler
`timescale 1ns/100ps
module modbus_output_write_analog_read_test;
  import modbus_slave_pkg::*;
  typedef logic [7:0] bytes_t[$];
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] unit_addr = 8'h01;
  rx_byte_t rx = '0;
  logic tx_ready;
  tx_byte_t tx;
  logic [NUM_OUT-1:0] coil_state;
  logic [NUM_AI-1:0][31:0] ain;
  logic stall = 1'b0;
  int err_total = 0;
  int compares = 0;

  always #25 clk = ~clk;

  modbus_output_write_analog_read DUT (
    .clk(clk), .sys_rst(sys_rst), .unit_addr(unit_addr), .rx(rx),
    .tx_ready(tx_ready), .tx(tx), .coil_state(coil_state),
    .analog_input_channel(ain));

  modbus_master_sink sink (
    .clk(clk), .stall(stall), .tx(tx), .tx_ready(tx_ready));

  // ********
  // shared helpers
  // ********
  function automatic logic [15:0] crc_of(bytes_t f);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // sends a frame with its checksum, then judges the whole reply
  task automatic xfer(bytes_t f, bytes_t r, bit bad);
    logic [15:0] c;
    int n;
    c = crc_of(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(negedge clk);
      rx = '{valid: 1'b1, eof: 1'b0, data: f[i]};
    end
    @(negedge clk);
    rx = '{valid: 1'b0, eof: 1'b1, data: 8'h00};
    @(negedge clk);
    rx = '0;
    if (r.size() > 0) begin
      c = crc_of(r);
      r.push_back(c[7:0]);
      r.push_back(c[15:8]);
    end
    n = 0;
    while (sink.got.size() < r.size() && n < 200) begin
      @(posedge clk);
      n++;
    end
    // extra bytes or a late reply would show up here
    repeat (8) @(posedge clk);
    chk(sink.got.size(), r.size());
    foreach (r[i]) chk(sink.got[i], {i == r.size() - 1, r[i]});
    sink.got.delete();
  endtask

  task automatic wr_one(logic [15:0] a, logic [15:0] v, bit ok);
    bytes_t f;
    bytes_t none;
    f = '{8'h01, 8'h05, a[15:8], a[7:0], v[15:8], v[7:0]};
    if (ok) xfer(f, f, 1'b0);
    else xfer(f, none, 1'b0);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_single();
    chk(crc_of('{8'h01, 8'h05, 8'h00, 8'h00, 8'hFF, 8'h00}), 16'h3A8C);
    wr_one(16'h0000, 16'hFF00, 1'b1);
    chk(coil_state, 16'h0001);
    wr_one(16'h000F, 16'hFF00, 1'b1);
    chk(coil_state, 16'h8001);
    stall = 1'b1;
    wr_one(16'h0000, 16'h0000, 1'b1);
    stall = 1'b0;
    chk(coil_state, 16'h8000);
    wr_one(16'h0001, 16'h1234, 1'b0);
    chk(coil_state, 16'h8000);
  endtask

  task automatic t_multi();
    chk(crc_of('{8'h01, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h10}), 16'h0754);
    xfer('{8'h01, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h10, 8'h02, 8'h55, 8'hAA},
      '{8'h01, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h10}, 1'b0);
    chk(coil_state, 16'hAA55);
    xfer('{8'h01, 8'h0F, 8'h00, 8'h04, 8'h00, 8'h03, 8'h01, 8'h02},
      '{8'h01, 8'h0F, 8'h00, 8'h04, 8'h00, 8'h03}, 1'b0);
    chk(coil_state, 16'hAA25);
  endtask

  task automatic t_read(logic [15:0] s, logic [15:0] n);
    bytes_t f;
    bytes_t r;
    logic [15:0] w;
    f = '{8'h01, 8'h04, s[15:8], s[7:0], n[15:8], n[7:0]};
    r = '{8'h01, 8'h04, {n[6:0], 1'b0}};
    for (int k = s; k < s + n; k++) begin
      w = k[0] ? ain[k >> 1][15:0] : ain[k >> 1][31:16];
      r.push_back(w[15:8]);
      r.push_back(w[7:0]);
    end
    xfer(f, r, 1'b0);
  endtask

  task automatic t_reject();
    bytes_t none;
    xfer('{8'h01, 8'h05, 8'h00, 8'h03, 8'hFF, 8'h00}, none, 1'b1);
    xfer('{8'h02, 8'h05, 8'h00, 8'h03, 8'hFF, 8'h00}, none, 1'b0);
    // byte count too small for sixteen outputs
    xfer('{8'h01, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h10, 8'h01, 8'h55},
      none, 1'b0);
    chk(coil_state, 16'hAA25);
  endtask

  // another configured address, then one outside the legal range
  task automatic t_unit();
    bytes_t none;
    @(negedge clk);
    unit_addr = 8'h02;
    xfer('{8'h02, 8'h05, 8'h00, 8'h03, 8'hFF, 8'h00},
      '{8'h02, 8'h05, 8'h00, 8'h03, 8'hFF, 8'h00}, 1'b0);
    chk(coil_state, 16'hAA2D);
    @(negedge clk);
    unit_addr = 8'h00;
    xfer('{8'h00, 8'h05, 8'h00, 8'h03, 8'h00, 8'h00}, none, 1'b0);
    chk(coil_state, 16'hAA2D);
    @(negedge clk);
    unit_addr = 8'h01;
  endtask

  initial begin
    for (int i = 0; i < NUM_AI; i++) ain[i] = 32'h0000044C * (i + 1);
    ain[7] = 32'hFFFFFC18;
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk(coil_state, 16'h0000);
    chk(tx.valid, 1'b0);
    t_single();
    t_multi();
    t_read(16'h0000, 16'h0010);
    stall = 1'b1;
    t_read(16'h0003, 16'h0004);
    stall = 1'b0;
    t_reject();
    t_unit();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule // modbus_output_write_analog_read_test
